//--- cadt_top.sv
// Update-rate timer and two debounced temperature warnings with power-good gating.
// Register port is the controller's internal settings access behind its serial management bus.
// How it works
// - Rate code selects refresh period 10.5, 52.4, 104.9 or 209.7 ms.
// - Reset leaves rate code 00, shortest refresh period.
// - Bit 7 selects warning two debounce: 0 is 100 ms, 1 none.
// - Bit 6 lets warning two assert the channel B power-good fault.
// - Bits 5:4 set warning two offset, one to four LSBs above trip two.
// - Bit 3 selects warning one debounce: 0 is 100 ms, 1 none.
// - Bit 2 lets warning one assert the channel A power-good fault.
// - Bits 1:0 set warning one offset, one to four LSBs above trip one.
// - Channel A power-good fault drives the power-good A pin low.
`timescale 1ns/1ps
`default_nettype none
module cadt_top
   import cadt_pkg::*;
#(
   parameter int unsigned TEMP_W        = 12,
   parameter int unsigned RATE0_CYCLES  = cadt_pkg::RATE0_CYC,
   parameter int unsigned RATE1_CYCLES  = cadt_pkg::RATE1_CYC,
   parameter int unsigned RATE2_CYCLES  = cadt_pkg::RATE2_CYC,
   parameter int unsigned RATE3_CYCLES  = cadt_pkg::RATE3_CYC,
   parameter int unsigned DEBOUNCE_CYCLES = cadt_pkg::DEBOUNCE_CYC
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire logic                    clkEn,
   input  wire cadt_pkg::cadt_reg_req_s regReq,
   output var  logic [7:0]              regRdData,
   input  wire logic [TEMP_W-1:0]       tempSenseOne,
   input  wire logic [TEMP_W-1:0]       tempSenseTwo,
   input  wire logic [TEMP_W-1:0]       overtempTripOne,
   input  wire logic [TEMP_W-1:0]       overtempTripTwo,
   input  wire logic                    otherFaultChanA,
   input  wire logic                    otherFaultChanB,
   output var  logic                    adcUpdateStrobe,
   output var  logic [1:0]              adcRateCode,
   output var  logic                    tempWarningOne,
   output var  logic                    tempWarningTwo,
   output var  logic                    pgFaultChanA,
   output var  logic                    pgFaultChanB,
   output var  logic                    powerGoodChanA,
   output var  logic                    powerGoodChanB
);
   import cadt_pkg::*;

   logic [7:0]          rateReg;
   logic [7:0]          warnReg;
   logic [CNT_W-1:0]    rateCnt_reg;
   logic [CNT_W-1:0]    ratePeriod;
   logic [CNT_W-1:0]    debCnt_reg [2];
   logic [1:0]          warnCond;
   logic [1:0]          warn_reg;
   cadt_warn_cfg_s      cfg [2];
   logic [1:0]          pgFaultNext;
   logic [1:0]          debDone;

   // Warning level sits offsetCode+1 LSBs above the trip level; sense at or below it warns
   function automatic logic warnHit(input logic [TEMP_W-1:0] sense,
                                    input logic [TEMP_W-1:0] trip,
                                    input logic [1:0]        code);
      logic [TEMP_W:0] level;
      level = {1'b0, trip} + {{(TEMP_W-1){1'b0}}, code} + {{TEMP_W{1'b0}}, 1'b1};
      return {1'b0, sense} <= level;
   endfunction : warnHit

   assign cfg[0] = cadt_warn_cfg_s'(warnReg[WARN_ONE_LSB +: WARN_FIELD_W]);
   assign cfg[1] = cadt_warn_cfg_s'(warnReg[WARN_TWO_LSB +: WARN_FIELD_W]);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rateReg <= RATE_RESET;
      end else if (clkEn && regReq.wrEn && regReq.addr == ADDR_RATE) begin
         rateReg <= regReq.wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         warnReg <= WARN_RESET;
      end else if (clkEn && regReq.wrEn && regReq.addr == ADDR_WARN) begin
         warnReg <= regReq.wrData;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regRdData <= UNMAPPED_READ;
      end else if (clkEn && regReq.rdEn) begin
         if (regReq.addr == ADDR_RATE) begin
            regRdData <= rateReg;
         end else if (regReq.addr == ADDR_WARN) begin
            regRdData <= warnReg;
         end else begin
            regRdData <= UNMAPPED_READ;
         end
      end
   end

   always_comb begin
      unique case (rateReg[RATE_LSB +: 2])
         2'b00: ratePeriod = CNT_W'(RATE0_CYCLES);
         2'b01: ratePeriod = CNT_W'(RATE1_CYCLES);
         2'b10: ratePeriod = CNT_W'(RATE2_CYCLES);
         2'b11: ratePeriod = CNT_W'(RATE3_CYCLES);
      endcase
   end

   // Refresh timer; >= so a shorter period takes effect at once
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rateCnt_reg     <= '0;
         adcUpdateStrobe <= 1'b0;
      end else if (clkEn) begin
         if (rateCnt_reg >= ratePeriod - CNT_W'(1)) begin
            rateCnt_reg     <= '0;
            adcUpdateStrobe <= 1'b1;
         end else begin
            rateCnt_reg     <= rateCnt_reg + CNT_W'(1);
            adcUpdateStrobe <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         adcRateCode <= 2'b00;
      end else if (clkEn) begin
         adcRateCode <= rateReg[RATE_LSB +: 2];
      end
   end

   assign warnCond[0] = warnHit(tempSenseOne, overtempTripOne, cfg[0].offsetCode);
   assign warnCond[1] = warnHit(tempSenseTwo, overtempTripTwo, cfg[1].offsetCode);

   // Count saturates at the end so a long hot spell cannot wrap it
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         debDone[i] = debCnt_reg[i] >= CNT_W'(DEBOUNCE_CYCLES) - CNT_W'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            debCnt_reg[i] <= '0;
         end
      end else if (clkEn) begin
         for (int i = 0; i < 2; i++) begin
            if (!warnCond[i]) begin
               debCnt_reg[i] <= '0;
            end else if (!cfg[i].noDebounce && !debDone[i]) begin
               debCnt_reg[i] <= debCnt_reg[i] + CNT_W'(1);
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         warn_reg <= 2'b00;
      end else if (clkEn) begin
         for (int i = 0; i < 2; i++) begin
            if (!warnCond[i]) begin
               warn_reg[i] <= 1'b0;
            end else if (cfg[i].noDebounce || debDone[i]) begin
               warn_reg[i] <= 1'b1;
            end
         end
      end
   end

   // One fault term feeds both flag and pin, so the two never disagree
   function automatic logic faultOf(input logic other,
                                    input logic warn,
                                    input logic feeds);
      return other | (warn & feeds);
   endfunction : faultOf

   always_comb begin
      pgFaultNext[0] = faultOf(otherFaultChanA, warn_reg[0], cfg[0].feedsPowerGood);
      pgFaultNext[1] = faultOf(otherFaultChanB, warn_reg[1], cfg[1].feedsPowerGood);
   end

   // Outputs registered so the pins change on the same edge as the flags, one edge after warn_reg
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tempWarningOne <= 1'b0;
         tempWarningTwo <= 1'b0;
      end else if (clkEn) begin
         tempWarningOne <= warn_reg[0];
         tempWarningTwo <= warn_reg[1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pgFaultChanA <= 1'b0;
         pgFaultChanB <= 1'b0;
      end else if (clkEn) begin
         pgFaultChanA <= pgFaultNext[0];
         pgFaultChanB <= pgFaultNext[1];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         powerGoodChanA <= 1'b1;
         powerGoodChanB <= 1'b1;
      end else if (clkEn) begin
         powerGoodChanA <= ~pgFaultNext[0];
         powerGoodChanB <= ~pgFaultNext[1];
      end
   end
endmodule : cadt_top
`default_nettype wire

//--- cadt_pkg.sv
// Constants, field layout and types for the current ADC rate and temperature warning block.
// Assumes a 50 MHz system clock; all timing counts derive from it.
`default_nettype none
package cadt_pkg;
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned CLK_PER_US      = CLK_HZ / 1_000_000;
   // Times in microseconds, as printed
   localparam int unsigned RATE0_US        = 10_500;
   localparam int unsigned RATE1_US        = 52_400;
   localparam int unsigned RATE2_US        = 104_900;
   localparam int unsigned RATE3_US        = 209_700;
   localparam int unsigned DEBOUNCE_US     = 100_000;
   localparam int unsigned RATE0_CYC       = RATE0_US * CLK_PER_US;
   localparam int unsigned RATE1_CYC       = RATE1_US * CLK_PER_US;
   localparam int unsigned RATE2_CYC       = RATE2_US * CLK_PER_US;
   localparam int unsigned RATE3_CYC       = RATE3_US * CLK_PER_US;
   localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_US * CLK_PER_US;
   localparam int unsigned CNT_W           = 24;

   // Register map
   localparam logic [15:0] ADDR_RATE       = 16'hFE89;
   localparam logic [15:0] ADDR_WARN       = 16'hFE8A;
   localparam logic [7:0]  RATE_RESET      = 8'h00;
   localparam logic [7:0]  WARN_RESET      = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

   // Field positions
   localparam int unsigned RATE_LSB        = 0;
   localparam int unsigned WARN_TWO_LSB    = 4;
   localparam int unsigned WARN_ONE_LSB    = 0;
   localparam int unsigned WARN_FIELD_W    = 4;

   typedef struct packed {
      logic       noDebounce;
      logic       feedsPowerGood;
      logic [1:0] offsetCode;
   } cadt_warn_cfg_s;

   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [15:0] addr;
      logic [7:0]  wrData;
   } cadt_reg_req_s;
endpackage : cadt_pkg
`default_nettype wire

//--- cadt_monitor.sv
// Port checker: refresh strobe, rate readback, warnings, power-good pins.
// Assumes clkEn held high.
`timescale 1ns/1ps
`default_nettype none
module cadt_monitor #(
   parameter int unsigned TEMP_W       = 12,
   parameter int unsigned RATE3_CYCLES = 10
) (
   input wire logic                    clk_sys,
   input wire logic                    rst,
   input wire logic                    adcUpdateStrobe,
   input wire logic                    tempWarningOne,
   input wire logic                    tempWarningTwo,
   input wire logic                    pgFaultChanA,
   input wire logic                    pgFaultChanB,
   input wire logic                    powerGoodChanA,
   input wire logic                    powerGoodChanB,
   input wire cadt_pkg::cadt_reg_req_s regReq,
   input wire logic [7:0]              regRdData,
   input wire logic [1:0]              adcRateCode,
   input wire logic [TEMP_W-1:0]       tempSenseOne,
   input wire logic [TEMP_W-1:0]       tempSenseTwo,
   input wire logic [TEMP_W-1:0]       overtempTripOne,
   input wire logic [TEMP_W-1:0]       overtempTripTwo
);
   import cadt_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_pin_a_low: assert property (powerGoodChanA != pgFaultChanA) else $error("pin A");
   a_pin_b_low: assert property (powerGoodChanB != pgFaultChanB) else $error("pin B");
   a_strobe_pulse: assert property (adcUpdateStrobe |=> !adcUpdateStrobe)
      else $error("strobe width");
   a_slow_period: assert property (adcUpdateStrobe && adcRateCode == 2'h3
      && RATE3_CYCLES == 10 |=> !adcUpdateStrobe [*8] ##1 !adcUpdateStrobe ##1 adcUpdateStrobe)
      else $error("slow period");
   a_rate_readback: assert property (regReq.rdEn && regReq.addr == ADDR_RATE
      |=> regRdData[1:0] == adcRateCode) else $error("rate readback");
   // Four codes above the trip is the widest window any offset allows
   a_one_rise: assert property ($rose(tempWarningOne)
      |-> $past({1'b0, tempSenseOne} <= {1'b0, overtempTripOne} + 4, 2)) else $error("rise one");
   a_two_rise: assert property ($rose(tempWarningTwo)
      |-> $past({1'b0, tempSenseTwo} <= {1'b0, overtempTripTwo} + 4, 2)) else $error("rise two");
   a_one_clear: assert property ({1'b0, tempSenseOne} > {1'b0, overtempTripOne} + 4
      |-> ##2 !tempWarningOne) else $error("clear one");
endmodule : cadt_monitor
bind cadt_top cadt_monitor #(.TEMP_W(TEMP_W), .RATE3_CYCLES(RATE3_CYCLES)) cadt_monitor_inst (.*);
`default_nettype wire

//--- cadt_host_model.sv
// Host model: single-byte settings writes and reads.
// Assumes clkEn high, so a request is taken at the next rising edge.
`timescale 1ns/1ps
`default_nettype none
module cadt_host_model (
   input  wire logic                    clk_sys,
   output var  cadt_pkg::cadt_reg_req_s regReq,
   input  wire logic [7:0]              regRdData
);
   import cadt_pkg::*;
   initial regReq = '0;
   // Held one cycle; read data taken at the falling edge after the read edge
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      @(negedge clk_sys);
      regReq <= '{wr, !wr, a, d};
      @(negedge clk_sys);
      regReq <= '0;
      q = regRdData;
   endtask : acc
endmodule : cadt_host_model
`default_nettype wire

//--- tb.sv
// Bench: reset and rate cases, then warning settings as table rows, then debounce and fault cases.
// Assumes the host model for register access; trips fixed, other faults driven only in the fault case.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cadt_pkg::*;
   localparam int PER [4] = '{4, 6, 8, 10};
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [11:0] sense = 12'hFFF;
   logic [7:0] rd, rdData;
   logic strobe, w1, w2, pg1, pg2;
   logic [1:0] code;
   logic ofa = 1'b0;
   logic ofb = 1'b0;
   cadt_reg_req_s req;
   int n_errors = 0;
   int checks_done = 0;
   int gap;
   // Settings nibble, sense code, expected warning and pin
   logic [17:0] rows [7] = '{{4'hC, 12'h065, 2'b10}, {4'hC, 12'h066, 2'b01},
      {4'hF, 12'h068, 2'b10}, {4'hF, 12'h069, 2'b01}, {4'h9, 12'h066, 2'b11},
      {4'hA, 12'h067, 2'b11}, {4'h4, 12'h05A, 2'b10}};
   always #10 clk_sys = ~clk_sys;
   // Short periods keep the run brief
   cadt_top #(.RATE0_CYCLES(PER[0]), .RATE1_CYCLES(PER[1]), .RATE2_CYCLES(PER[2]),
      .RATE3_CYCLES(PER[3]), .DEBOUNCE_CYCLES(8)) cadt_top_inst (.clk_sys, .rst,
      .clkEn(1'b1), .regReq(req), .regRdData(rdData), .tempSenseOne(sense),
      .tempSenseTwo(sense), .overtempTripOne(12'h064), .overtempTripTwo(12'h064),
      .otherFaultChanA(ofa), .otherFaultChanB(ofb), .adcUpdateStrobe(strobe),
      .adcRateCode(code), .tempWarningOne(w1), .tempWarningTwo(w2), .pgFaultChanA(),
      .pgFaultChanB(), .powerGoodChanA(pg1), .powerGoodChanB(pg2));
   cadt_host_model cadt_host_model_inst (.clk_sys, .regReq(req), .regRdData(rdData));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      cadt_host_model_inst.acc(w, a, d, rd);
   endtask : acc
   // Bounded wait; a missing strobe ends the run
   task automatic nextStrobe;
      gap = 0;
      do begin
         @(negedge clk_sys);
         gap++;
      end while (strobe !== 1'b1 && gap < 40);
      if (gap >= 40) begin
         n_errors++;
         end_sim();
      end
   endtask : nextStrobe
   initial begin
      cyc(6);
      rst = 1'b0;
      acc(1'b0, ADDR_RATE, 8'h00);
      chk(rd, RATE_RESET);
      chk({6'h00, code}, 8'h00);
      acc(1'b1, 16'hFE8B, 8'h55);
      acc(1'b0, 16'hFE8B, 8'h00);
      chk(rd, UNMAPPED_READ);
      $display("reset test done");
      // Reserved bits set in every code to show they leave the period alone
      for (int c = 0; c < 4; c++) begin
         acc(1'b1, ADDR_RATE, 8'hA8 + 8'(c));
         acc(1'b0, ADDR_RATE, 8'h00);
         chk(rd, 8'hA8 + 8'(c));
         nextStrobe();
         nextStrobe();
         chk(8'(gap), 8'(PER[c]));
      end
      $display("rate test done");
      foreach (rows[i]) begin
         sense = rows[i][13:2];
         acc(1'b1, ADDR_WARN, {2{rows[i][17:14]}});
         cyc(14);
         chk({w1, pg1, w2, pg2}, {2{rows[i][1:0]}});
      end
      $display("settings rows done");
      sense = 12'hFFF;
      acc(1'b1, ADDR_WARN, 8'h44);
      cyc(4);
      sense = 12'h065;
      cyc(6);
      sense = 12'h066;
      cyc(1);
      sense = 12'h065;
      cyc(7);
      chk({w1, w2, pg1}, 3'b001);
      cyc(5);
      chk({w1, w2, pg1, pg2}, 4'b1100);
      $display("debounce test done");
      sense = 12'hFFF;
      cyc(3);
      {ofa, ofb} = 2'b10;
      cyc(2);
      chk({pg1, pg2}, 2'b01);
      {ofa, ofb} = 2'b01;
      cyc(2);
      chk({pg1, pg2}, 2'b10);
      {ofa, ofb} = 2'b00;
      $display("fault input test done");
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      acc(1'b0, ADDR_RATE, 8'h00);
      chk(rd, RATE_RESET);
      acc(1'b0, ADDR_WARN, 8'h00);
      chk(rd, WARN_RESET);
      chk({4'h0, code, pg1, pg2}, 8'h03);
      $display("mid-run reset test done");
      end_sim();
   end
endmodule : tb
`default_nettype wire
